// ==== design/ptc_test_counters.sv ====
`timescale 1ns/1ps
// How it works
// - eight-bit errored byte count in low byte
// - writing command bit 0 locks counter values
// - writing command bit 1 locks, then zeroes counters
// - mode zero: errored count stops at 0xFF
// - packet counter overflow flag at bit 10
// - byte counter overflow flag at bit 9
// - flags stay until lock-and-clear clears them
// - packet length field, resets to 1500
// - idle gap equals eight-bit units times four bytes, plus two clocks
// - gap register resets to 125 units
// - sixteen-bit byte total, locked, saturating in mode zero and wrapping in mode one
module ptc_test_counters
	import ptc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic chk_byte_valid,
	input wire logic chk_byte_error,
	input wire logic chk_packet_end,
	output logic gen_valid,
	output logic gen_first,
	output logic gen_last,
	output logic [7:0] gen_data,
	output logic irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] pkt_len;
		logic [7:0] ipg;
		logic count_mode;
		logic gen_enable;
		logic [7:0] err_cnt;
		logic [15:0] byte_total;
		logic [15:0] pkt_cnt;
		logic [7:0] lock_err;
		logic [15:0] lock_byte;
		logic [15:0] lock_pkt;
		logic byte_ovf;
		logic pkt_ovf;
		logic [IRQ_WIDTH-1:0] irq_status;
		logic [IRQ_WIDTH-1:0] irq_mask;
	} ptc_regs_s;

	ptc_regs_s cur;
	ptc_regs_s next_cur;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// returns {overflow, next value}; at the limit wrap to zero or hold
	function automatic logic [16:0] bump(input logic [15:0] v, input logic [15:0] maxv,
		input logic wrap);
		if (v == maxv) begin
			return {1'b1, (wrap ? 16'h0000 : v)};
		end
		return {1'b0, 16'(v + 16'h0001)};
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = d[7:0];
		end
		if (strb[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return a == ADDR_BYTE_TOTAL || a == ADDR_ERR_CMD || a == ADDR_PKT_LEN
			|| a == ADDR_IPG || a == ADDR_CTRL || a == ADDR_PKT_COUNT
			|| a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK;
	endfunction

	logic [16:0] err_step;
	logic [16:0] byte_step;
	logic [16:0] pkt_step;
	logic do_write;
	logic cmd_lock;
	logic cmd_clear;
	logic [31:0] read_word;

	// ------------------------------------------------------------
	// counter steps
	// ------------------------------------------------------------
	// mode zero saturates, any other mode wraps
	assign err_step = bump({8'h00, cur.err_cnt}, ERR_CNT_MAX, cur.count_mode);
	assign byte_step = bump(cur.byte_total, WORD16_MAX, cur.count_mode);
	assign pkt_step = bump(cur.pkt_cnt, WORD16_MAX, cur.count_mode);

	assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;
	assign cmd_lock = do_write && cur.aw_addr == ADDR_ERR_CMD && cur.w_strb[0]
		&& cur.w_data[CMD_LOCK_BIT];
	assign cmd_clear = do_write && cur.aw_addr == ADDR_ERR_CMD && cur.w_strb[0]
		&& cur.w_data[CMD_LOCK_CLEAR_BIT];

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	always_comb begin
		read_word = 32'h0000_0000;
		unique case (s_axi_araddr)
			ADDR_BYTE_TOTAL: read_word = {16'h0000, cur.lock_byte};
			ADDR_ERR_CMD: begin
				read_word[7:0] = cur.lock_err;
				read_word[BYTE_OVF_BIT] = cur.byte_ovf;
				read_word[PKT_OVF_BIT] = cur.pkt_ovf;
			end
			ADDR_PKT_LEN: read_word = {16'h0000, cur.pkt_len};
			ADDR_IPG: read_word = {24'h000000, cur.ipg};
			ADDR_CTRL: begin
				read_word[CTRL_COUNT_MODE_BIT] = cur.count_mode;
				read_word[CTRL_GEN_ENABLE_BIT] = cur.gen_enable;
			end
			ADDR_PKT_COUNT: read_word = {16'h0000, cur.lock_pkt};
			ADDR_IRQ_STATUS: read_word[IRQ_WIDTH-1:0] = cur.irq_status;
			ADDR_IRQ_MASK: read_word[IRQ_WIDTH-1:0] = cur.irq_mask;
			default: read_word = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;

		// write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end

		// live counters fed by the checker
		if (chk_byte_valid) begin
			next_cur.byte_total = byte_step[15:0];
			if (byte_step[16]) begin
				next_cur.byte_ovf = 1'b1;
				next_cur.irq_status[IRQ_BYTE_OVF_BIT] = 1'b1;
			end
			if (chk_byte_error) begin
				next_cur.err_cnt = err_step[7:0];
				next_cur.irq_status[IRQ_ERR_BIT] = 1'b1;
			end
		end
		if (chk_packet_end) begin
			next_cur.pkt_cnt = pkt_step[15:0];
			if (pkt_step[16]) begin
				next_cur.pkt_ovf = 1'b1;
				next_cur.irq_status[IRQ_PKT_OVF_BIT] = 1'b1;
			end
		end

		// register write, answered one cycle after both halves are held
		if (do_write) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = is_mapped(cur.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			unique case (cur.aw_addr)
				ADDR_PKT_LEN: next_cur.pkt_len = merge16(cur.pkt_len, cur.w_data,
					cur.w_strb);
				ADDR_IPG: begin
					if (cur.w_strb[0]) begin
						next_cur.ipg = cur.w_data[7:0];
					end
				end
				ADDR_CTRL: begin
					if (cur.w_strb[0]) begin
						next_cur.count_mode = cur.w_data[CTRL_COUNT_MODE_BIT];
						next_cur.gen_enable = cur.w_data[CTRL_GEN_ENABLE_BIT];
					end
				end
				ADDR_IRQ_MASK: begin
					if (cur.w_strb[0]) begin
						next_cur.irq_mask = cur.w_data[IRQ_WIDTH-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// lock takes a snapshot of the live counters for reading
		if (cmd_lock || cmd_clear) begin
			next_cur.lock_err = cur.err_cnt;
			next_cur.lock_byte = cur.byte_total;
			next_cur.lock_pkt = cur.pkt_cnt;
		end
		// lock-and-clear zeroes counters and flags; a new overflow still wins
		if (cmd_clear) begin
			next_cur.err_cnt = 8'h00;
			next_cur.byte_total = 16'h0000;
			next_cur.pkt_cnt = 16'h0000;
			next_cur.byte_ovf = chk_byte_valid && byte_step[16];
			next_cur.pkt_ovf = chk_packet_end && pkt_step[16];
		end

		// interrupt status cleared by writing one, a new event wins
		if (do_write && cur.aw_addr == ADDR_IRQ_STATUS && cur.w_strb[0]) begin
			next_cur.irq_status = cur.irq_status & ~cur.w_data[IRQ_WIDTH-1:0];
			if (chk_byte_valid && chk_byte_error) begin
				next_cur.irq_status[IRQ_ERR_BIT] = 1'b1;
			end
			if (chk_byte_valid && byte_step[16]) begin
				next_cur.irq_status[IRQ_BYTE_OVF_BIT] = 1'b1;
			end
			if (chk_packet_end && pkt_step[16]) begin
				next_cur.irq_status[IRQ_PKT_OVF_BIT] = 1'b1;
			end
		end

		// read channel
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata = read_word;
			next_cur.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
			cur.pkt_len <= PKT_LEN_RESET;
			cur.ipg <= IPG_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = !cur.aw_held && !cur.bvalid;
	assign s_axi_wready = !cur.w_held && !cur.bvalid;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = !cur.rvalid;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
	assign irq = |(cur.irq_status & cur.irq_mask);

	ptc_pkt_gen u_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(cur.gen_enable),
		.packet_length(cur.pkt_len),
		.gap_units(cur.ipg),
		.gen_valid(gen_valid),
		.gen_first(gen_first),
		.gen_last(gen_last),
		.gen_data(gen_data)
	);

endmodule

// ==== common/ptc_pkg.sv ====
package ptc_pkg;

	// ------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] IDX_BYTE_TOTAL = 12'h071;
	localparam logic [11:0] IDX_ERR_CMD = 12'h072;
	localparam logic [11:0] IDX_PKT_LEN = 12'h07B;
	localparam logic [11:0] IDX_IPG = 12'h07C;
	localparam logic [11:0] ADDR_BYTE_TOTAL = 12'(IDX_BYTE_TOTAL * 4);
	localparam logic [11:0] ADDR_ERR_CMD = 12'(IDX_ERR_CMD * 4);
	localparam logic [11:0] ADDR_PKT_LEN = 12'(IDX_PKT_LEN * 4);
	localparam logic [11:0] ADDR_IPG = 12'(IDX_IPG * 4);
	localparam logic [11:0] ADDR_CTRL = 12'h200;
	localparam logic [11:0] ADDR_PKT_COUNT = 12'h204;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h208;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h20C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CMD_LOCK_BIT = 0;
	localparam int CMD_LOCK_CLEAR_BIT = 1;
	localparam int BYTE_OVF_BIT = 9;
	localparam int PKT_OVF_BIT = 10;
	localparam int CTRL_COUNT_MODE_BIT = 0;
	localparam int CTRL_GEN_ENABLE_BIT = 1;
	localparam int IRQ_ERR_BIT = 0;
	localparam int IRQ_BYTE_OVF_BIT = 1;
	localparam int IRQ_PKT_OVF_BIT = 2;
	localparam int IRQ_WIDTH = 3;

	// ------------------------------------------------------------
	// reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] PKT_LEN_RESET = 16'h05DC;
	localparam logic [7:0] IPG_RESET = 8'h7D;
	localparam logic [15:0] ERR_CNT_MAX = 16'h00FF;
	localparam logic [15:0] WORD16_MAX = 16'hFFFF;
	localparam logic [15:0] GAP_BYTES_PER_UNIT = 16'h0004;
	localparam logic [7:0] LFSR_SEED = 8'h7F;

	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PTC_GEN_IDLE = 2'h0,
		PTC_GEN_PACKET = 2'h1,
		PTC_GEN_GAP = 2'h3
	} ptc_gen_state_e;

endpackage

// ==== design/ptc_pkt_gen.sv ====
`timescale 1ns/1ps
module ptc_pkt_gen
	import ptc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic [15:0] packet_length,
	input wire logic [7:0] gap_units,
	output logic gen_valid,
	output logic gen_first,
	output logic gen_last,
	output logic [7:0] gen_data
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		ptc_gen_state_e state;
		logic [15:0] count;
		logic [7:0] lfsr;
		logic valid;
		logic first;
		logic last;
		logic [7:0] data;
	} ptc_gen_s;

	ptc_gen_s cur;
	ptc_gen_s next_cur;

	// eight steps of x^7 + x^6 + 1 give one fresh byte
	function automatic logic [7:0] lfsr_byte(input logic [7:0] v);
		logic [7:0] s;
		s = v;
		for (int i = 0; i < 8; i++) begin
			s = {s[6:0], s[6] ^ s[5]};
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.valid = 1'b0;
		next_cur.first = 1'b0;
		next_cur.last = 1'b0;
		unique case (cur.state)
			PTC_GEN_IDLE: begin
				if (enable && packet_length != 16'h0000) begin
					next_cur.state = PTC_GEN_PACKET;
					next_cur.count = 16'h0000;
				end
			end
			PTC_GEN_PACKET: begin
				// one byte per clock until the programmed length is sent
				next_cur.valid = 1'b1;
				next_cur.first = (cur.count == 16'h0000);
				next_cur.data = cur.lfsr;
				next_cur.lfsr = lfsr_byte(cur.lfsr);
				next_cur.count = 16'(cur.count + 16'h0001);
				if (16'(cur.count + 16'h0001) >= packet_length) begin
					next_cur.last = 1'b1;
					next_cur.count = 16'h0000;
					next_cur.state = PTC_GEN_GAP;
				end
			end
			PTC_GEN_GAP: begin
				// idle gap of four bytes per programmed unit
				if (cur.count >= 16'({8'h00, gap_units} * GAP_BYTES_PER_UNIT)) begin
					next_cur.count = 16'h0000;
					next_cur.state = PTC_GEN_IDLE;
				end else begin
					next_cur.count = 16'(cur.count + 16'h0001);
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '{state: PTC_GEN_IDLE, count: 16'h0000, lfsr: LFSR_SEED, valid: 1'b0,
				first: 1'b0, last: 1'b0, data: 8'h00};
		end else begin
			cur <= next_cur;
		end
	end

	assign gen_valid = cur.valid;
	assign gen_first = cur.first;
	assign gen_last = cur.last;
	assign gen_data = cur.data;

endmodule

// ==== verification/ptc_sva.sv ====
`timescale 1ns/1ps
module ptc_sva
	import ptc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gen_valid,
	input wire logic gen_first,
	input wire logic gen_last
);
	// ------------------------------------------------------------
	// bus and generator properties
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
	property p_err_rsvd;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_ERR_CMD
			|=> s_axi_rdata[31:11] == 21'h0 && !s_axi_rdata[8];
	endproperty
	a_err_rsvd: assert property (p_err_rsvd) else $error("reserved bits set");
	property p_ipg_width;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_IPG |=> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_ipg_width: assert property (p_ipg_width) else $error("gap field too wide");
	property p_pkt_body;
		gen_valid && !gen_last |=> gen_valid && !gen_first;
	endproperty
	a_pkt_body: assert property (p_pkt_body) else $error("packet broken");
	property p_pkt_gap;
		gen_last |=> !gen_valid [*2];
	endproperty
	a_pkt_gap: assert property (p_pkt_gap) else $error("gap missing");
	property p_marks;
		gen_first || gen_last |-> gen_valid;
	endproperty
	a_marks: assert property (p_marks) else $error("mark without byte");
endmodule

// ==== verification/ptc_rx_model.sv ====
`timescale 1ns/1ps
module ptc_rx_model (
	input wire logic aclk,
	output logic byte_valid,
	output logic byte_error,
	output logic packet_end
);
	// ------------------------------------------------------------
	// received byte stream
	// ------------------------------------------------------------
	initial begin
		byte_valid = 1'b0;
		byte_error = 1'b1;
		packet_end = 1'b0;
	end
	task automatic send(input int n, input logic err, input logic pend);
		for (int i = 0; i < n; i++) begin
			byte_valid <= 1'b1;
			byte_error <= err;
			packet_end <= pend;
			@(posedge aclk);
		end
		byte_valid <= 1'b0;
		byte_error <= ~err;
		packet_end <= 1'b0;
	endtask
endmodule

// ==== verification/ptc_test_counters_tb_top.sv ====
`timescale 1ns/1ps
module ptc_test_counters_tb_top
	import ptc_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic gen_valid, gen_first, gen_last, byte_valid, byte_error, packet_end;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] gen_data;
	int bad_count, checks, g1, g2, len;
	logic [7:0] d1, d2;
	ptc_test_counters dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.chk_byte_valid(byte_valid), .chk_byte_error(byte_error), .chk_packet_end(packet_end),
		.gen_valid(gen_valid), .gen_first(gen_first), .gen_last(gen_last), .gen_data(gen_data),
		.irq(irq));
	ptc_rx_model rx_u (.aclk(aclk), .byte_valid(byte_valid), .byte_error(byte_error),
		.packet_end(packet_end));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tk;
		int n;
		n = 0;
		tk = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!tk) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid && s_axi_bready;
			if (tk) cmp(32'(s_axi_bresp), 32'(er));
			@(posedge aclk);
			n++;
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (n == 3) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, tk;
		int n;
		n = 0;
		tk = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!tk) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid && s_axi_rready;
			if (tk) cmp(s_axi_rdata, e);
			if (tk) cmp(32'(s_axi_rresp), 32'(er));
			@(posedge aclk);
			n++;
			if (ta) s_axi_arvalid <= 1'b0;
			if (n == 3) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		@(negedge aclk);
		cmp(32'(irq), 32'(e));
		@(posedge aclk);
	endtask
	task automatic gm(output int l, output int gap, output logic [7:0] fd);
		l = 0;
		gap = 0;
		fd = 8'h00;
		@(negedge aclk);
		while (!gen_first) @(negedge aclk);
		fd = gen_data;
		while (!gen_last) begin
			l++;
			@(negedge aclk);
		end
		l++;
		@(negedge aclk);
		while (!gen_valid) begin
			gap++;
			@(negedge aclk);
		end
		@(posedge aclk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// clock, watchdog, tests
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		repeat (80000) @(posedge aclk);
		bad_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ADDR_PKT_LEN, 32'h05DC, RESP_OKAY);
		rd(ADDR_IPG, 32'h007D, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h0, RESP_OKAY);
		rd(12'h100, 32'h0, RESP_SLVERR);
		wr(12'h100, 32'h1, RESP_SLVERR);
		rx_u.send(300, 1'b1, 1'b0);
		wr(ADDR_ERR_CMD, 32'h1, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h00FF, RESP_OKAY);
		rd(ADDR_BYTE_TOTAL, 32'd300, RESP_OKAY);
		irq_is(1'b0);
		rd(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
		wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
		irq_is(1'b1);
		wr(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
		irq_is(1'b0);
		wr(ADDR_ERR_CMD, 32'h2, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h00FF, RESP_OKAY);
		wr(ADDR_ERR_CMD, 32'h1, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h0, RESP_OKAY);
		rd(ADDR_BYTE_TOTAL, 32'h0, RESP_OKAY);
		rx_u.send(5, 1'b1, 1'b0);
		wr(ADDR_ERR_CMD, 32'h1, RESP_OKAY);
		rx_u.send(2, 1'b0, 1'b0);
		rd(ADDR_ERR_CMD, 32'h5, RESP_OKAY);
		rd(ADDR_BYTE_TOTAL, 32'h5, RESP_OKAY);
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wr(ADDR_IRQ_MASK, 32'h6, RESP_OKAY);
		rd(ADDR_IRQ_MASK, 32'h6, RESP_OKAY);
		rx_u.send(65536, 1'b0, 1'b1);
		irq_is(1'b1);
		wr(ADDR_ERR_CMD, 32'h1, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h0605, RESP_OKAY);
		rd(ADDR_BYTE_TOTAL, 32'h7, RESP_OKAY);
		rd(ADDR_PKT_COUNT, 32'h0, RESP_OKAY);
		wr(ADDR_ERR_CMD, 32'h1, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h0605, RESP_OKAY);
		wr(ADDR_ERR_CMD, 32'h2, RESP_OKAY);
		rd(ADDR_ERR_CMD, 32'h0005, RESP_OKAY);
		wr(ADDR_IRQ_STATUS, 32'h6, RESP_OKAY);
		irq_is(1'b0);
		wr(ADDR_PKT_LEN, 32'h3, RESP_OKAY);
		rd(ADDR_PKT_LEN, 32'h3, RESP_OKAY);
		wr(ADDR_IPG, 32'h1, RESP_OKAY);
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		gm(len, g1, d1);
		gm(len, g1, d2);
		cmp(32'(len), 32'd3);
		cmp(32'(d1 != d2), 32'd1);
		rd(ADDR_CTRL, 32'h2, RESP_OKAY);
		wr(ADDR_IPG, 32'h2, RESP_OKAY);
		gm(len, g2, d1);
		gm(len, g2, d2);
		cmp(32'(g2 - g1), 32'd4);
		complete_run();
	end
endmodule
bind ptc_test_counters ptc_sva chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .gen_valid(gen_valid), .gen_first(gen_first),
	.gen_last(gen_last));
